// ===== core/gpdl_defs.svh
/*
 * Constants for the gigabit PCS datapath latency block: clock rates,
 * pipeline depths and receive elastic buffer geometry.
 * Assumes inclusion by bare name from the datapath files.
 */
`ifndef GPDL_DEFS_SVH
`define GPDL_DEFS_SVH

// ==========================================================================
// Core clock rates
// ==========================================================================
`define GPDL_CORE_MHZ_1G         125.0
`define GPDL_CORE_MHZ_2G5        312.5
`define GPDL_LINE_MBPS_1G        1250.0
`define GPDL_LINE_MBPS_2G5       3125.0

// ==========================================================================
// Pipeline depths in core clock periods
// ==========================================================================
`define GPDL_TBI_TX_DEPTH        5
`define GPDL_TBI_RX_FIXED        16
`define GPDL_XCVR_TX_DEPTH       4
`define GPDL_XCVR_RX_DEPTH       6

// ==========================================================================
// Receive elastic buffer
// ==========================================================================
`define GPDL_EB_DEPTH            32
`define GPDL_EB_AW               5
`define GPDL_EB_HALF             6'h10
`define GPDL_EB_EMPTY            6'h00
`define GPDL_EB_ONE              6'h01
`define GPDL_EB_PTR_ONE          5'h01
`define GPDL_SYM_W               10
`define GPDL_IDLE_WORD           10'h000
`define GPDL_DV_BIT              8
`define GPDL_ER_BIT              9

`endif

// ===== core/gpdl_pkg.sv
/*
 * Types for the gigabit PCS datapath latency block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package gpdl_pkg;

	// Line side variant in use
	typedef enum logic [1:0] {
		gpdl_line_tbi,
		gpdl_line_xcvr,
		gpdl_line_sgmii
	} gpdl_line_mode_type;

	// Receive elastic buffer regulation action
	typedef enum logic [1:0] {
		gpdl_eb_pass,
		gpdl_eb_insert,
		gpdl_eb_delete
	} gpdl_eb_action_type;

endpackage

// ===== core/gpdl_datapath.sv
/*
 * Gigabit PCS datapath with fixed transmit and receive pipeline depths
 * for the ten-bit interface variant and the 8-bit transceiver variant.
 * Assumes the line side inputs are synchronous to clk_sys, that the core
 * clock is 125 MHz (1 Gb/s) or 312.5 MHz (2.5 Gb/s), and that line coding
 * is done outside: the 10-bit word carries {er, dv, data}.
 */
`timescale 1ns/1ps
`default_nettype none
`include "gpdl_defs.svh"

module gpdl_datapath (
	// Clock and reset
	input  wire logic                        clk_sys,
	input  wire logic                        reset_n,
	// Configuration
	input  wire gpdl_pkg::gpdl_line_mode_type line_mode,
	input  wire logic                        rate_2g5,
	// GMII transmit from the MAC
	input  wire logic [7:0]                  gmii_txd,
	input  wire logic                        gmii_tx_en,
	input  wire logic                        gmii_tx_er,
	// GMII receive to the MAC
	output logic      [7:0]                  gmii_rxd,
	output logic                             gmii_rx_dv,
	output logic                             gmii_rx_er,
	// Ten-bit interface
	output logic      [9:0]                  tbi_tx_symbol,
	input  wire logic [9:0]                  tbi_rx_symbol_even,
	input  wire logic [9:0]                  tbi_rx_symbol_odd,
	// 8-bit transceiver interface
	output logic      [7:0]                  xcvr_txdata,
	input  wire logic [7:0]                  xcvr_rxdata,
	// Status
	output logic      [5:0]                  eb_occupancy,
	output logic                             tbi_active
);
	import gpdl_pkg::*;

	// ======================================================================
	// Variant selection
	// ======================================================================
	logic use_tbi;

	// TBI exists only at 1 Gb/s; SGMII falls to the transceiver path
	assign use_tbi    = (line_mode == gpdl_line_tbi) && !rate_2g5;
	assign tbi_active = use_tbi;

	// ======================================================================
	// Transmit pipelines
	// ======================================================================
	logic [9:0] tx_tbi_pipe      [`GPDL_TBI_TX_DEPTH];
	logic [9:0] next_tx_tbi_pipe [`GPDL_TBI_TX_DEPTH];
	logic [7:0] tx_xc_pipe       [`GPDL_XCVR_TX_DEPTH];
	logic [7:0] next_tx_xc_pipe  [`GPDL_XCVR_TX_DEPTH];

	// One stage per clock, a word accepted every cycle
	always_comb begin
		next_tx_tbi_pipe[0] = {gmii_tx_er, gmii_tx_en, gmii_txd};
		for (int i = 1; i < `GPDL_TBI_TX_DEPTH; i++) begin
			next_tx_tbi_pipe[i] = tx_tbi_pipe[i-1];
		end
		next_tx_xc_pipe[0] = gmii_txd;
		for (int i = 1; i < `GPDL_XCVR_TX_DEPTH; i++) begin
			next_tx_xc_pipe[i] = tx_xc_pipe[i-1];
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < `GPDL_TBI_TX_DEPTH; i++) begin
				tx_tbi_pipe[i] <= `GPDL_IDLE_WORD;
			end
			for (int i = 0; i < `GPDL_XCVR_TX_DEPTH; i++) begin
				tx_xc_pipe[i] <= 8'h00;
			end
		end else begin
			tx_tbi_pipe <= next_tx_tbi_pipe;
			tx_xc_pipe  <= next_tx_xc_pipe;
		end
	end

	// Last stages face the line side
	assign tbi_tx_symbol = tx_tbi_pipe[`GPDL_TBI_TX_DEPTH-1];
	assign xcvr_txdata   = tx_xc_pipe[`GPDL_XCVR_TX_DEPTH-1];

	// ======================================================================
	// Receive elastic buffer (TBI)
	// ======================================================================
	logic [9:0]  eb_mem [`GPDL_EB_DEPTH];
	logic [4:0]  wr_ptr, next_wr_ptr;
	logic [4:0]  rd_ptr, next_rd_ptr;
	logic [5:0]  occ, next_occ;
	logic        odd_sel, next_odd_sel;
	logic [9:0]  eb_out, next_eb_out;
	logic [9:0]  rx_word;
	logic        do_write, do_read;
	gpdl_eb_action_type action;

	// Words arrive alternately on the even and odd buses; the first edge
	// after reset or after entering the TBI path takes the even bus
	assign rx_word = odd_sel ? tbi_rx_symbol_odd : tbi_rx_symbol_even;

	// Regulation toward half full touches idle words only. An idle is
	// inserted only while the buffer is empty, the MAC side already sees one or the head is one,
	// so the fill after reset never splits a frame and does not stall on data
	always_comb begin
		action = gpdl_eb_pass;
		if (occ > `GPDL_EB_HALF && rx_word == `GPDL_IDLE_WORD) begin
			action = gpdl_eb_delete;
		end else if (occ < `GPDL_EB_HALF && (occ == `GPDL_EB_EMPTY ||
				eb_out == `GPDL_IDLE_WORD || eb_mem[rd_ptr] == `GPDL_IDLE_WORD)) begin
			action = gpdl_eb_insert;
		end
		do_write = use_tbi && (action != gpdl_eb_delete);
		do_read  = use_tbi && (action != gpdl_eb_insert) && (occ != `GPDL_EB_EMPTY);
	end

	// Pointer, occupancy and read data next values
	always_comb begin
		next_odd_sel = use_tbi ? !odd_sel : 1'b0;
		next_wr_ptr  = do_write ? wr_ptr + `GPDL_EB_PTR_ONE : wr_ptr;
		next_rd_ptr  = do_read ? rd_ptr + `GPDL_EB_PTR_ONE : rd_ptr;
		next_occ     = occ;
		if (do_write && !do_read) begin
			next_occ = occ + `GPDL_EB_ONE;
		end else if (!do_write && do_read) begin
			next_occ = occ - `GPDL_EB_ONE;
		end
		next_eb_out = do_read ? eb_mem[rd_ptr] : `GPDL_IDLE_WORD;
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr  <= 5'h00;
			rd_ptr  <= 5'h00;
			occ     <= 6'h00;
			odd_sel <= 1'b0;
			eb_out  <= `GPDL_IDLE_WORD;
		end else begin
			wr_ptr  <= next_wr_ptr;
			rd_ptr  <= next_rd_ptr;
			occ     <= next_occ;
			odd_sel <= next_odd_sel;
			eb_out  <= next_eb_out;
		end
	end

	// Storage array, no reset needed: a word is read only after it is
	// written, and the empty test keeps stale entries out of the decisions
	always_ff @(posedge clk_sys) begin
		if (do_write) begin
			eb_mem[wr_ptr] <= rx_word;
		end
	end

	// Occupancy counts stored words; the read register is not among them
	assign eb_occupancy = occ;

	// ======================================================================
	// Receive pipelines
	// ======================================================================
	logic [9:0] rx_tbi_pipe      [`GPDL_TBI_RX_FIXED-2];
	logic [9:0] next_rx_tbi_pipe [`GPDL_TBI_RX_FIXED-2];
	logic [7:0] rx_xc_pipe       [`GPDL_XCVR_RX_DEPTH-1];
	logic [7:0] next_rx_xc_pipe  [`GPDL_XCVR_RX_DEPTH-1];
	logic [9:0] next_gmii_word;

	// Read register, these stages and the output register add 16 edges to
	// the write edge and the buffer wait: 15 periods plus the occupancy
	always_comb begin
		next_rx_tbi_pipe[0] = eb_out;
		for (int i = 1; i < `GPDL_TBI_RX_FIXED - 2; i++) begin
			next_rx_tbi_pipe[i] = rx_tbi_pipe[i-1];
		end
		next_rx_xc_pipe[0] = xcvr_rxdata;
		for (int i = 1; i < `GPDL_XCVR_RX_DEPTH - 1; i++) begin
			next_rx_xc_pipe[i] = rx_xc_pipe[i-1];
		end
		if (use_tbi) begin
			next_gmii_word = rx_tbi_pipe[`GPDL_TBI_RX_FIXED-3];
		end else begin
			next_gmii_word = {2'b01, rx_xc_pipe[`GPDL_XCVR_RX_DEPTH-2]};
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < `GPDL_TBI_RX_FIXED - 2; i++) begin
				rx_tbi_pipe[i] <= `GPDL_IDLE_WORD;
			end
			for (int i = 0; i < `GPDL_XCVR_RX_DEPTH - 1; i++) begin
				rx_xc_pipe[i] <= 8'h00;
			end
			gmii_rxd   <= 8'h00;
			gmii_rx_dv <= 1'b0;
			gmii_rx_er <= 1'b0;
		end else begin
			rx_tbi_pipe <= next_rx_tbi_pipe;
			rx_xc_pipe  <= next_rx_xc_pipe;
			gmii_rxd    <= next_gmii_word[7:0];
			gmii_rx_dv  <= next_gmii_word[`GPDL_DV_BIT];
			gmii_rx_er  <= next_gmii_word[`GPDL_ER_BIT];
		end
	end

endmodule

`default_nettype wire

// ===== bench/gpdl_mac_model.sv
/* MAC model on the GMII client side: random octets back to back.
   Assumes the bench clock on clk_sys; changes land at the falling edge. */
`timescale 1ns/1ps
`default_nettype none
module gpdl_mac_model (
	// Clock
	input  wire logic       clk_sys,
	// GMII transmit towards the core
	output logic      [7:0] gmii_txd,
	output logic            gmii_tx_en,
	output logic            gmii_tx_er
);
	logic [9:0] r;
	initial {gmii_tx_er, gmii_tx_en, gmii_txd} = 10'h000;
	// New word on every cycle with no gaps
	always @(negedge clk_sys) begin
		r = 10'($urandom);
		{gmii_tx_er, gmii_tx_en, gmii_txd} <= r;
	end
endmodule
`default_nettype wire

// ===== bench/gpdl_datapath_assertions.sv
/* Checker for the datapath latencies, bound to the top module.
   Assumes one core clock and the settle count of its own helper. */
`timescale 1ns/1ps
`default_nettype none
module gpdl_datapath_assertions (
	// Clock, reset and configuration
	input  wire logic                         clk_sys,
	input  wire logic                         reset_n,
	input  wire gpdl_pkg::gpdl_line_mode_type line_mode,
	input  wire logic                         rate_2g5,
	// Data and status
	input  wire logic [7:0]                   gmii_txd,
	input  wire logic                         gmii_tx_en,
	input  wire logic                         gmii_tx_er,
	input  wire logic [7:0]                   gmii_rxd,
	input  wire logic                         gmii_rx_dv,
	input  wire logic                         gmii_rx_er,
	input  wire logic [9:0]                   tbi_tx_symbol,
	input  wire logic [7:0]                   xcvr_txdata,
	input  wire logic [7:0]                   xcvr_rxdata,
	input  wire logic [5:0]                   eb_occupancy,
	input  wire logic                         tbi_active
);
	import gpdl_pkg::*;
	logic [5:0] settle;
	logic [2:0] cfg;
	logic       fresh;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// ==========================================================
	// Edges since reset or the last configuration change
	// ==========================================================
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			settle <= 6'h00;
			fresh  <= 1'b1;
			cfg    <= 3'h0;
		end else begin
			cfg <= {line_mode, rate_2g5};
			if ({line_mode, rate_2g5} != cfg && settle != 6'h00) begin
				settle <= 6'h00;
				fresh  <= 1'b0;
			end else if (settle != 6'h3f) begin
				settle <= settle + 6'h01;
			end
		end
	end
	a_tbi_tx_delay: assert property (tbi_active && settle >= 6'h08 |->
		tbi_tx_symbol == $past({gmii_tx_er, gmii_tx_en, gmii_txd}, 5)) else $error("tbi tx latency");
	a_xcvr_tx_delay: assert property (!tbi_active && settle >= 6'h08 |->
		xcvr_txdata == $past(gmii_txd, 4)) else $error("xcvr tx latency");
	a_xcvr_rx_delay: assert property (!tbi_active && settle >= 6'h08 |->
		gmii_rxd == $past(xcvr_rxdata, 6)) else $error("xcvr rx latency");
	a_xcvr_rx_flags: assert property (!tbi_active && settle >= 6'h08 |->
		gmii_rx_dv && !gmii_rx_er) else $error("xcvr rx flags");
	a_mode_decode: assert property (tbi_active ==
		(line_mode == gpdl_line_tbi && !rate_2g5)) else $error("tbi select");
	a_occ_regulated: assert property (tbi_active && settle >= 6'h28 |->
		eb_occupancy inside {[6'h0f:6'h11]}) else $error("occupancy off half");
	a_occ_bound: assert property (eb_occupancy <= 6'h20) else $error("occupancy over depth");
	a_fill_idle: assert property (fresh && tbi_active && settle inside {[6'h01:6'h10]}
		|-> !gmii_rx_dv && !gmii_rx_er) else $error("data during fill");
endmodule
bind gpdl_datapath gpdl_datapath_assertions u_chk (.clk_sys(clk_sys), .reset_n(reset_n),
	.line_mode(line_mode), .rate_2g5(rate_2g5), .gmii_txd(gmii_txd), .gmii_tx_en(gmii_tx_en),
	.gmii_tx_er(gmii_tx_er), .gmii_rxd(gmii_rxd), .gmii_rx_dv(gmii_rx_dv),
	.gmii_rx_er(gmii_rx_er), .tbi_tx_symbol(tbi_tx_symbol), .xcvr_txdata(xcvr_txdata),
	.xcvr_rxdata(xcvr_rxdata), .eb_occupancy(eb_occupancy), .tbi_active(tbi_active));
`default_nettype wire

// ===== bench/gpdl_datapath_tb.sv
/* Self-checking bench: history queue model against every output.
   Assumes the MAC model drives transmit; the bench drives the line side. */
`timescale 1ns/1ps
`default_nettype none
module gpdl_datapath_tb;
	import gpdl_pkg::*;
	logic clk_sys = 1'b0, reset_n = 1'b0, rate_2g5 = 1'b0;
	gpdl_line_mode_type line_mode = gpdl_line_tbi;
	logic [7:0] gmii_txd, gmii_rxd, xcvr_txdata, xcvr_rxdata = 8'h00;
	logic gmii_tx_en, gmii_tx_er, gmii_rx_dv, gmii_rx_er, tbi_active, odd_turn = 1'b0;
	logic [9:0] tbi_tx_symbol, rx_word = 10'h100;
	logic [5:0] eb_occupancy;
	logic [27:0] hq[$];
	logic [31:0] r;
	int miscompares = 0, total_checks = 0, cyc = 0, ticks = 0;
	gpdl_mac_model u_mac (.clk_sys(clk_sys), .gmii_txd(gmii_txd), .gmii_tx_en(gmii_tx_en),
		.gmii_tx_er(gmii_tx_er));
	// Word on the bus due at this edge, its inverse on the other one
	gpdl_datapath u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .line_mode(line_mode),
		.rate_2g5(rate_2g5), .gmii_txd(gmii_txd), .gmii_tx_en(gmii_tx_en),
		.gmii_tx_er(gmii_tx_er), .gmii_rxd(gmii_rxd), .gmii_rx_dv(gmii_rx_dv),
		.gmii_rx_er(gmii_rx_er), .tbi_tx_symbol(tbi_tx_symbol),
		.tbi_rx_symbol_even(odd_turn ? ~rx_word : rx_word),
		.tbi_rx_symbol_odd(odd_turn ? rx_word : ~rx_word),
		.xcvr_txdata(xcvr_txdata), .xcvr_rxdata(xcvr_rxdata),
		.eb_occupancy(eb_occupancy), .tbi_active(tbi_active));
	initial forever #10 clk_sys = ~clk_sys;
	task check(input logic [9:0] seen, input logic [9:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task final_report;
		if (miscompares == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ==========================================================
	// Model: inputs of each cycle queued, outputs compared by depth
	// ==========================================================
	always @(negedge clk_sys) begin
		hq.push_back({gmii_tx_er, gmii_tx_en, gmii_txd, rx_word, xcvr_rxdata});
		if (hq.size() > 40)
			void'(hq.pop_front());
		cyc = reset_n ? cyc + 1 : 0;
		if (cyc >= 40) begin
			check({9'h000, tbi_active}, {9'h000, line_mode == gpdl_line_tbi && !rate_2g5});
			if (line_mode == gpdl_line_tbi && !rate_2g5) begin
				check(tbi_tx_symbol, hq[$-4][27:18]);
				check({gmii_rx_er, gmii_rx_dv, gmii_rxd}, hq[$-31][17:8]);
				check({4'h0, eb_occupancy}, 10'h010);
			end else begin
				check({2'b00, xcvr_txdata}, {2'b00, hq[$-3][25:18]});
				check({gmii_rx_er, gmii_rx_dv, gmii_rxd}, {2'b01, hq[$-5][7:0]});
			end
		end
		r = $urandom;
		rx_word <= (r[31:28] == 4'h0) ? 10'h000 : {r[9], 1'b1, r[7:0]};
		odd_turn <= cyc[0];
		xcvr_rxdata <= r[17:10];
		ticks++;
		if (ticks == 5000) begin
			miscompares++;
			final_report;
		end
	end
	// Phases: tbi, xcvr, sgmii, then tbi selected at 2.5G
	initial begin
		void'($urandom(33517));
		for (int p = 0; p < 4; p++) begin
			reset_n <= 1'b0;
			line_mode <= gpdl_line_mode_type'(p % 3);
			rate_2g5 <= (p == 3);
			repeat (16) @(negedge clk_sys);
			reset_n <= 1'b1;
			repeat (200) @(negedge clk_sys);
		end
		final_report;
	end
endmodule
`default_nettype wire
